/* File: piw_params.svh */
// Timing constants for the interrupt-acknowledge wait-state generator
`ifndef PIW_PARAMS_SVH
`define PIW_PARAMS_SVH
`define PIW_CLK_PERIOD_NS 100
`define PIW_ACK_LEAD_MIN_NS 40
`define PIW_ACK_LEAD_MAX_NS 240
`define PIW_WAIT_SHORT 1
`define PIW_WAIT_LONG 2
`define PIW_WAIT_INTACK 4
`define PIW_PARK_EXIT_CLOCKS 2
`define PIW_SEQ_RESET 3'h6
`endif

/* File: piw_pkg.sv */
// Types shared by the wait-state generator
package piw_pkg;
    typedef struct packed {
        logic function_code_bit2;
        logic function_code_bit1;
        logic function_code_bit0;
    } piw_fc_s;
    typedef struct packed {
        logic rd;
        logic wr;
    } piw_strobe_s;
endpackage : piw_pkg

/* File: piw_intack_waitgen.sv */
// Bus glue: interrupt-acknowledge decode, strobes and wait-state sequencer
//
// Operation
// - One wait state with select negated, two when asserted, ordinary cycles.
// - Interrupt acknowledge always inserts five wait states.
// - Lower strobe registered; read needs registered copy, delaying read edge.
// - Read strobe generated during acknowledge so peripheral drives vector.
// - Select one wait at 4 MHz, two at 6 MHz and above.
// - Acknowledge may lead valid read data by at most 40 to 240 ns.
`timescale 1ns/1ps
`include "piw_params.svh"

module piw_intack_waitgen (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic address_strobe_i,
    input wire logic lower_data_strobe_i,
    input wire logic read_not_write_i,
    input wire logic wait_count_select_i,
    input wire piw_pkg::piw_fc_s function_code_i,
    output logic intack_decode_o,
    output logic data_transfer_ack_o,
    output piw_pkg::piw_strobe_s periph_strobe_o
);
    // Strobes are active high here; pin inversion lives outside.
    logic seq_a_reg;
    logic seq_b_reg;
    logic seq_c_reg;
    logic delayed_lower_strobe_reg;
    logic ack_next;
    logic rd_next;
    logic wr_next;
    logic intack_next;
    logic ack_short;
    logic ack_long;
    logic ack_intack;
    logic ack_hold;
    logic [2:0] busy_clocks_reg;

    assign intack_next = function_code_i.function_code_bit0 &
        function_code_i.function_code_bit1 &
        function_code_i.function_code_bit2 & address_strobe_i;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            delayed_lower_strobe_reg <= 1'b0;
        end else begin
            delayed_lower_strobe_reg <= lower_data_strobe_i;
        end
    end

    // sequencer stepping; idle strobe and reset park it at 110
    // Parking on reset lets a cycle right after reset count its waits in full
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {seq_a_reg, seq_b_reg, seq_c_reg} <= `PIW_SEQ_RESET;
        end else begin
            seq_a_reg <= (seq_a_reg & ~seq_b_reg) | (seq_b_reg & seq_c_reg)
                | ~address_strobe_i;
            seq_b_reg <= (seq_a_reg ^ seq_c_reg) | ~address_strobe_i;
            seq_c_reg <= address_strobe_i &
                ((~seq_a_reg & ~seq_b_reg) | (seq_b_reg & seq_c_reg));
        end
    end

    // one wait: sequencer back at all zeros
    assign ack_short = ~intack_next & ~seq_a_reg & ~seq_b_reg & ~seq_c_reg
        & ~wait_count_select_i;

    // two waits: integrator picks select by clock rate
    assign ack_long = ~intack_next & ~seq_a_reg & ~seq_b_reg & seq_c_reg
        & wait_count_select_i;

    // interrupt acknowledge: only the late sequencer states answer
    assign ack_intack = intack_next & seq_a_reg & ~seq_b_reg;

    // hold until the processor lets go of the strobe
    assign ack_hold = data_transfer_ack_o & lower_data_strobe_i;

    always_comb begin
        ack_next = ack_short | ack_long | ack_intack | ack_hold;
    end

    // Clocks since address strobe, for the wait-count checks below
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_clocks_reg <= 3'h0;
        end else if (!address_strobe_i) begin
            busy_clocks_reg <= 3'h0;
        end else if (busy_clocks_reg != 3'h7) begin
            busy_clocks_reg <= busy_clocks_reg + 3'h1;
        end
    end

    // read in acknowledge comes from the sequencer, not the strobe
    always_comb begin
        rd_next = (lower_data_strobe_i & delayed_lower_strobe_reg
                & read_not_write_i & ~intack_next)
            | (seq_a_reg & seq_c_reg & intack_next)
            | (seq_a_reg & ~seq_b_reg & intack_next);
        wr_next = lower_data_strobe_i & ~read_not_write_i;
    end

    // registered outputs; glitch-free pins, ack never runs early
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_transfer_ack_o <= 1'b0;
            periph_strobe_o <= '0;
            intack_decode_o <= 1'b0;
        end else begin
            data_transfer_ack_o <= ack_next;
            periph_strobe_o.rd <= rd_next;
            periph_strobe_o.wr <= wr_next;
            intack_decode_o <= intack_next;
        end
    end

    a_write_follows: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        lower_data_strobe_i && !read_not_write_i |=> periph_strobe_o.wr)
        else $error("write strobe missing");

    a_write_quiet: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !(lower_data_strobe_i && !read_not_write_i) |=> !periph_strobe_o.wr)
        else $error("write strobe without write");

    a_read_delayed: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $rose(lower_data_strobe_i) && !intack_next |=> !periph_strobe_o.rd)
        else $error("read edge not delayed");

    a_read_normal: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        lower_data_strobe_i && delayed_lower_strobe_reg && read_not_write_i
        && !intack_next |=> periph_strobe_o.rd)
        else $error("ordinary read strobe missing");

    a_intack_decode: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        intack_next |=> intack_decode_o)
        else $error("acknowledge decode missed");

    a_ack_hold: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        data_transfer_ack_o && lower_data_strobe_i |=> data_transfer_ack_o)
        else $error("acknowledge dropped early");

    a_parked_quiet: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        seq_b_reg && !(data_transfer_ack_o && lower_data_strobe_i)
        |=> !data_transfer_ack_o)
        else $error("acknowledge from busy sequencer");

    a_idle_park: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !address_strobe_i |=> seq_a_reg && seq_b_reg && !seq_c_reg)
        else $error("sequencer not parked");

    a_ack_one_wait: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !intack_next && !wait_count_select_i && !seq_a_reg && !seq_b_reg
        && !seq_c_reg |=> data_transfer_ack_o)
        else $error("short wait acknowledge missing");

    a_ack_two_wait: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !intack_next && wait_count_select_i && !seq_a_reg && !seq_b_reg
        && seq_c_reg |=> data_transfer_ack_o)
        else $error("long wait acknowledge missing");

    a_short_count: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $rose(data_transfer_ack_o) && !intack_decode_o && !wait_count_select_i
        |-> busy_clocks_reg == `PIW_WAIT_SHORT + `PIW_PARK_EXIT_CLOCKS)
        else $error("short wait count wrong");

    a_long_count: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $rose(data_transfer_ack_o) && !intack_decode_o && wait_count_select_i
        |-> busy_clocks_reg == `PIW_WAIT_LONG + `PIW_PARK_EXIT_CLOCKS)
        else $error("long wait count wrong");

    a_intack_ack: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        intack_next && seq_a_reg && !seq_b_reg |=> data_transfer_ack_o)
        else $error("intack acknowledge missing");

    a_intack_early: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        intack_next && !seq_a_reg && !(data_transfer_ack_o && lower_data_strobe_i)
        |=> !data_transfer_ack_o)
        else $error("intack acknowledge too early");

    a_intack_read: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        intack_next && seq_a_reg && seq_c_reg |=> periph_strobe_o.rd)
        else $error("vector read missing");

    c_intack: cover property (@(posedge core_clk_i) disable iff (rst_i)
        intack_decode_o && data_transfer_ack_o);
    c_read: cover property (@(posedge core_clk_i) disable iff (rst_i)
        periph_strobe_o.rd && data_transfer_ack_o && !intack_decode_o);
    c_write: cover property (@(posedge core_clk_i) disable iff (rst_i)
        periph_strobe_o.wr && data_transfer_ack_o);
    c_long_wait: cover property (@(posedge core_clk_i) disable iff (rst_i)
        data_transfer_ack_o && wait_count_select_i && !intack_decode_o);
    c_ack_held: cover property (@(posedge core_clk_i) disable iff (rst_i)
        data_transfer_ack_o && $past(data_transfer_ack_o));
endmodule : piw_intack_waitgen

/* File: piw_host_model.sv */
// Host bus master model issuing lower-byte transfers
`timescale 1ns/1ps
module piw_host_model (
    input wire logic core_clk_i,
    input wire logic data_transfer_ack_i,
    output logic address_strobe_o = 1'b0,
    output logic lower_data_strobe_o = 1'b0,
    output logic read_not_write_o = 1'b1,
    output piw_pkg::piw_fc_s function_code_o = 3'h0
);
    // sole master, no interrupt levels or enable
    task automatic xfer(input logic rw, input logic [2:0] fc, output int lat);
        lat = -1;
        @(posedge core_clk_i) #1 {address_strobe_o, lower_data_strobe_o,
            read_not_write_o, function_code_o} = {2'h3, rw, fc};
        for (int i = 1; i < 20 && lat < 0; i++) begin
            @(posedge core_clk_i);
            if (data_transfer_ack_i === 1'b1) lat = i;
        end
        #1 {address_strobe_o, lower_data_strobe_o} = 2'h0;
    endtask : xfer
endmodule : piw_host_model

/* File: piw_intack_waitgen_test.sv */
// Bench for the wait-state generator: cycle table, strobes, reset
`timescale 1ns/1ps
module piw_intack_waitgen_test;
    logic core_clk = 1'b0, rst = 1'b1, w0 = 1'b0;
    logic addr_stb, lower_data_strobe, rw, ack, ia, ia_seen;
    piw_pkg::piw_fc_s fc;
    piw_pkg::piw_strobe_s stb;
    int fails = 0, comparisons = 0, cyc = 0, lat, base, at [2];
    // Row: read, wait select, function code, extra clocks over the first row
    // Acknowledge cycles answer four clocks after the one-wait point
    logic [7:0] rows [6] = '{8'hA8, 8'h28, 8'hF1, 8'h49, 8'hBC, 8'hFC};
    always #50 core_clk = ~core_clk;
    piw_host_model host_u (.core_clk_i(core_clk), .data_transfer_ack_i(ack),
        .address_strobe_o(addr_stb), .lower_data_strobe_o(lower_data_strobe),
        .read_not_write_o(rw), .function_code_o(fc));
    piw_intack_waitgen dut_u (.core_clk_i(core_clk), .rst_i(rst),
        .address_strobe_i(addr_stb), .lower_data_strobe_i(lower_data_strobe),
        .read_not_write_i(rw), .wait_count_select_i(w0), .function_code_i(fc),
        .intack_decode_o(ia), .data_transfer_ack_o(ack), .periph_strobe_o(stb));
    always @(posedge core_clk) begin
        cyc = lower_data_strobe ? cyc + 1 : 0;
        for (int k = 0; k < 2; k++) if (stb[k] === 1'b1 && at[k] == 0) at[k] = cyc;
        if (cyc == 2) ia_seen = ia;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (2) @(posedge core_clk) #1;
        chk({ia, ack, stb}, 8'h00);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            w0 = rows[i][6];
            at = '{0, 0};
            host_u.xfer(rows[i][7], rows[i][5:3], lat);
            if (i == 0) base = lat;
            chk(lat, base + rows[i][2:0]);
            if (lat < 0) results();
            chk(at[0], rows[i][7] ? 0 : 2);
            chk(at[1] != 0, rows[i][7]);
            if (rows[i][5:3] != 3'h7) chk(at[1], rows[i][7] ? 3 : 0);
            chk(ia_seen, rows[i][5:3] == 3'h7);
            $display("row %0d done", i);
        end
        // Mid-run reset, then an ordinary read must time as the first row
        rst = 1'b1;
        repeat (2) @(posedge core_clk) #1;
        chk({ia, ack, stb}, 8'h00);
        rst = 1'b0;
        w0 = 1'b0;
        at = '{0, 0};
        host_u.xfer(1'b1, 3'h5, lat);
        chk(lat, base);
        chk(at[1], 3);
        $display("reset test done");
        results();
    end
endmodule : piw_intack_waitgen_test
